// ### fcled_pkg.sv
// Shared constants, types and register map of the fan status LED sequencer
package fcled_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned FAST_FLASH_PER_S = 3;
  localparam int unsigned SLOW_FLASH_PER_S = 1;
  localparam int unsigned SHORT_PAUSE_S = 2;
  localparam int unsigned LONG_PAUSE_S = 5;
  // Each flash is half on, half off
  localparam int unsigned FAST_HALF_CYC = CLK_HZ / (2 * FAST_FLASH_PER_S);
  localparam int unsigned SLOW_HALF_CYC = CLK_HZ / (2 * SLOW_FLASH_PER_S);
  localparam int unsigned SHORT_PAUSE_CYC = CLK_HZ * SHORT_PAUSE_S;
  localparam int unsigned LONG_PAUSE_CYC = CLK_HZ * LONG_PAUSE_S;
  localparam int unsigned TMR_W = 32;

  // ==========================================================================
  // Register map
  localparam int unsigned AXI_AW = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
  localparam logic CTRL_EN_RST = 1'h1;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned IRQ_ERR_BIT = 0;
  localparam int unsigned IRQ_DEM_BIT = 1;
  localparam int unsigned IRQ_SEQ_BIT = 2;
  localparam int unsigned ST_STATE_LSB = 0;
  localparam int unsigned ST_STAGE_LSB = 4;
  localparam int unsigned ST_CODE_LSB = 8;
  localparam int unsigned ST_ERRM_BIT = 12;
  localparam int unsigned ST_ERRC_BIT = 13;
  localparam int unsigned ST_RPM_LSB = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Profile pins, pin 4 in bit 3, ON reads as 1
  localparam logic [3:0] PROF_A = 4'hC;
  localparam logic [3:0] PROF_B = 4'hB;
  localparam logic [3:0] PROF_C = 4'h9;
  localparam logic [9:0] RPM_A_LOW = 10'h1DB;
  localparam logic [9:0] RPM_A_HIGH = 10'h226;
  localparam logic [9:0] RPM_A_RED = 10'h0C8;
  localparam logic [9:0] RPM_B_LOW = 10'h20D;
  localparam logic [9:0] RPM_B_HIGH = 10'h258;
  localparam logic [9:0] RPM_B_RED = 10'h0E1;
  localparam logic [9:0] RPM_C_LOW = 10'h258;
  localparam logic [9:0] RPM_C_HIGH = 10'h2A3;
  localparam logic [9:0] RPM_C_RED = 10'h0E1;
  localparam logic [3:0] CODE_A_LOW = 4'h6;
  localparam logic [3:0] CODE_A_HIGH = 4'h8;
  localparam logic [3:0] CODE_B_LOW = 4'h7;
  localparam logic [3:0] CODE_B_HIGH = 4'h8;
  localparam logic [3:0] CODE_C_LOW = 4'h8;
  localparam logic [3:0] CODE_C_HIGH = 4'h9;
  localparam logic [3:0] CODE_RED = 4'h3;

  // ==========================================================================
  // Types
  // Stage value equals its number of slow flashes
  typedef enum logic [1:0] {
    FCLED_STG_NONE = 2'h0,
    FCLED_STG_LOW = 2'h1,
    FCLED_STG_HIGH = 2'h2,
    FCLED_STG_REDUCED = 2'h3
  } fcled_stage_t;

  typedef enum logic [2:0] {
    FCLED_IDLE = 3'h0,
    FCLED_STG_ON = 3'h1,
    FCLED_STG_OFF = 3'h3,
    FCLED_LPAUSE = 3'h2,
    FCLED_SPD_ON = 3'h6,
    FCLED_SPD_OFF = 3'h7,
    FCLED_SPAUSE = 3'h5,
    FCLED_ERR = 3'h4
  } fcled_state_t;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } fcled_axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } fcled_axil_rsp_t;

endpackage : fcled_pkg

// ### fcled_timer.sv
// Down-counting interval timer for flash and pause lengths
`timescale 1ns/10ps
module fcled_timer #(
  parameter int unsigned W = 32
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  output logic done
);

  logic [W-1:0] cnt_reg;

  // ==========================================================================
  // Counter
  // A load of N gives done N cycles later; a load wins over counting
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else if (load) begin
      cnt_reg <= load_val;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - W'(1);
    end
  end

  assign done = (cnt_reg == W'(1));

endmodule : fcled_timer

// ### fcled_seq.sv
// Fan status LED sequencer with speed profile decode and AXI4-Lite registers
//
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
module fcled_seq #(
  parameter int unsigned FAST_HALF_CYC = fcled_pkg::FAST_HALF_CYC,
  parameter int unsigned SLOW_HALF_CYC = fcled_pkg::SLOW_HALF_CYC,
  parameter int unsigned SHORT_PAUSE_CYC = fcled_pkg::SHORT_PAUSE_CYC,
  parameter int unsigned LONG_PAUSE_CYC = fcled_pkg::LONG_PAUSE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire fcled_pkg::fcled_axil_req_t axil_req,
  output fcled_pkg::fcled_axil_rsp_t axil_rsp,
  input wire logic first_stage_demand,
  input wire logic second_stage_demand,
  input wire logic [3:0] profile_pins,
  input wire logic speed_mismatch,
  input wire logic crc_fail,
  output logic status_led,
  output logic [9:0] motor_drive_rpm,
  output logic irq
);

  localparam int unsigned TW = fcled_pkg::TMR_W;
  localparam logic [TW-1:0] T_FAST = TW'(FAST_HALF_CYC);
  localparam logic [TW-1:0] T_SLOW = TW'(SLOW_HALF_CYC);
  localparam logic [TW-1:0] T_SHORT = TW'(SHORT_PAUSE_CYC);
  localparam logic [TW-1:0] T_LONG = TW'(LONG_PAUSE_CYC);

  // ==========================================================================
  // Stage and profile decode
  fcled_pkg::fcled_stage_t stage_now;
  logic [3:0] code_low;
  logic [3:0] code_high;
  logic [9:0] rpm_low;
  logic [9:0] rpm_high;
  logic [9:0] rpm_red;

  always_comb begin
    unique case ({first_stage_demand, second_stage_demand})
      2'b10: stage_now = fcled_pkg::FCLED_STG_LOW;
      2'b11: stage_now = fcled_pkg::FCLED_STG_HIGH;
      2'b01: stage_now = fcled_pkg::FCLED_STG_REDUCED;
      default: stage_now = fcled_pkg::FCLED_STG_NONE;
    endcase
  end

  // Unknown pin settings give zero speed and low/high code: no drive, and speed flashes only for the reduced stage (CODE_RED)
  always_comb begin
    code_low = 4'h0;
    code_high = 4'h0;
    rpm_low = 10'h000;
    rpm_high = 10'h000;
    rpm_red = 10'h000;
    if (profile_pins == fcled_pkg::PROF_A) begin
      code_low = fcled_pkg::CODE_A_LOW;
      code_high = fcled_pkg::CODE_A_HIGH;
      rpm_low = fcled_pkg::RPM_A_LOW;
      rpm_high = fcled_pkg::RPM_A_HIGH;
      rpm_red = fcled_pkg::RPM_A_RED;
    end else if (profile_pins == fcled_pkg::PROF_B) begin
      code_low = fcled_pkg::CODE_B_LOW;
      code_high = fcled_pkg::CODE_B_HIGH;
      rpm_low = fcled_pkg::RPM_B_LOW;
      rpm_high = fcled_pkg::RPM_B_HIGH;
      rpm_red = fcled_pkg::RPM_B_RED;
    end else if (profile_pins == fcled_pkg::PROF_C) begin
      code_low = fcled_pkg::CODE_C_LOW;
      code_high = fcled_pkg::CODE_C_HIGH;
      rpm_low = fcled_pkg::RPM_C_LOW;
      rpm_high = fcled_pkg::RPM_C_HIGH;
      rpm_red = fcled_pkg::RPM_C_RED;
    end
  end

  // ==========================================================================
  // Motor target, follows the live demand
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      motor_drive_rpm <= 10'h000;
    end else begin
      unique case (stage_now)
        fcled_pkg::FCLED_STG_LOW: motor_drive_rpm <= rpm_low;
        fcled_pkg::FCLED_STG_HIGH: motor_drive_rpm <= rpm_high;
        fcled_pkg::FCLED_STG_REDUCED: motor_drive_rpm <= rpm_red;
        fcled_pkg::FCLED_STG_NONE: motor_drive_rpm <= 10'h000;
      endcase
    end
  end

  // ==========================================================================
  // Sequencer
  fcled_pkg::fcled_state_t state_reg;
  fcled_pkg::fcled_state_t state_next;
  fcled_pkg::fcled_stage_t stage_reg;
  logic [3:0] code_reg;
  logic [3:0] code_sel;
  logic [3:0] flash_reg;
  logic [3:0] flash_next;
  logic blink_reg;
  logic blink_next;
  logic tmr_load;
  logic [TW-1:0] tmr_val;
  logic tmr_done;
  logic err_any;
  logic err_q;
  logic ctrl_en_reg;
  logic ev_err;
  logic ev_dem;
  logic ev_seq;

  assign err_any = speed_mismatch | crc_fail;

  always_comb begin
    unique case (stage_now)
      fcled_pkg::FCLED_STG_LOW: code_sel = code_low;
      fcled_pkg::FCLED_STG_HIGH: code_sel = code_high;
      fcled_pkg::FCLED_STG_REDUCED: code_sel = fcled_pkg::CODE_RED;
      fcled_pkg::FCLED_STG_NONE: code_sel = 4'h0;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    flash_next = flash_reg;
    blink_next = blink_reg;
    tmr_load = 1'b0;
    tmr_val = T_FAST;
    if (err_any) begin
      // Error overrides any indication in progress
      if (state_reg != fcled_pkg::FCLED_ERR) begin
        state_next = fcled_pkg::FCLED_ERR;
        tmr_load = 1'b1;
        blink_next = 1'b1;
      end else if (tmr_done) begin
        tmr_load = 1'b1;
        blink_next = ~blink_reg;
      end
    end else begin
      unique case (state_reg)
        fcled_pkg::FCLED_IDLE: begin
          if (ctrl_en_reg && stage_now != fcled_pkg::FCLED_STG_NONE) begin
            state_next = fcled_pkg::FCLED_STG_ON;
            flash_next = {2'h0, stage_now};
            tmr_load = 1'b1;
            tmr_val = T_SLOW;
          end
        end
        fcled_pkg::FCLED_STG_ON: begin
          if (tmr_done) begin
            state_next = fcled_pkg::FCLED_STG_OFF;
            tmr_load = 1'b1;
            tmr_val = T_SLOW;
          end
        end
        fcled_pkg::FCLED_STG_OFF: begin
          if (tmr_done) begin
            tmr_load = 1'b1;
            if (flash_reg > 4'h1) begin
              state_next = fcled_pkg::FCLED_STG_ON;
              flash_next = flash_reg - 4'h1;
              tmr_val = T_SLOW;
            end else begin
              state_next = fcled_pkg::FCLED_LPAUSE;
              tmr_val = T_LONG;
            end
          end
        end
        fcled_pkg::FCLED_LPAUSE: begin
          if (tmr_done) begin
            tmr_load = 1'b1;
            if (code_reg != 4'h0) begin
              state_next = fcled_pkg::FCLED_SPD_ON;
              flash_next = code_reg;
              tmr_val = T_SLOW;
            end else begin
              state_next = fcled_pkg::FCLED_SPAUSE;
              tmr_val = T_SHORT;
            end
          end
        end
        fcled_pkg::FCLED_SPD_ON: begin
          if (tmr_done) begin
            state_next = fcled_pkg::FCLED_SPD_OFF;
            tmr_load = 1'b1;
            tmr_val = T_SLOW;
          end
        end
        fcled_pkg::FCLED_SPD_OFF: begin
          if (tmr_done) begin
            tmr_load = 1'b1;
            if (flash_reg > 4'h1) begin
              state_next = fcled_pkg::FCLED_SPD_ON;
              flash_next = flash_reg - 4'h1;
              tmr_val = T_SLOW;
            end else begin
              state_next = fcled_pkg::FCLED_SPAUSE;
              tmr_val = T_SHORT;
            end
          end
        end
        fcled_pkg::FCLED_SPAUSE: begin
          if (tmr_done) begin
            state_next = fcled_pkg::FCLED_IDLE;
          end
        end
        fcled_pkg::FCLED_ERR: begin
          state_next = fcled_pkg::FCLED_IDLE;
        end
      endcase
    end
  end

  fcled_timer #(
    .W(TW)
  ) u_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .load(tmr_load),
    .load_val(tmr_val),
    .done(tmr_done)
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= fcled_pkg::FCLED_IDLE;
      flash_reg <= 4'h0;
      blink_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      flash_reg <= flash_next;
      blink_reg <= blink_next;
    end
  end

  // Stage and code are frozen for a whole pass so a demand change cannot garble a code
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stage_reg <= fcled_pkg::FCLED_STG_NONE;
      code_reg <= 4'h0;
    end else if (ev_dem) begin
      stage_reg <= stage_now;
      code_reg <= code_sel;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      status_led <= 1'b0;
    end else begin
      unique case (state_next)
        fcled_pkg::FCLED_STG_ON, fcled_pkg::FCLED_SPD_ON: status_led <= 1'b1;
        fcled_pkg::FCLED_ERR: status_led <= crc_fail | blink_next;
        default: status_led <= 1'b0;
      endcase
    end
  end

  // ==========================================================================
  // Events
  assign ev_dem = (state_reg == fcled_pkg::FCLED_IDLE) && (state_next == fcled_pkg::FCLED_STG_ON);
  assign ev_seq = (state_reg == fcled_pkg::FCLED_SPAUSE) && (state_next == fcled_pkg::FCLED_IDLE);
  assign ev_err = err_any & ~err_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      err_q <= 1'b0;
    end else begin
      err_q <= err_any;
    end
  end

  // ==========================================================================
  // AXI4-Lite slave
  logic aw_got_reg;
  logic w_got_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic wstrb0_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [2:0] irq_stat_reg;
  logic [2:0] irq_mask_reg;
  logic do_write;
  logic wr_ok;
  logic [2:0] irq_set;
  logic [2:0] irq_clr;
  logic [31:0] status_word;

  assign do_write = aw_got_reg & w_got_reg & ~bvalid_reg;
  assign wr_ok = do_write & wstrb0_reg;
  assign axil_rsp.awready = ~aw_got_reg & ~bvalid_reg;
  assign axil_rsp.wready = ~w_got_reg & ~bvalid_reg;
  assign axil_rsp.bvalid = bvalid_reg;
  assign axil_rsp.bresp = bresp_reg;
  assign axil_rsp.arready = ~rvalid_reg;
  assign axil_rsp.rvalid = rvalid_reg;
  assign axil_rsp.rdata = rdata_reg;
  assign axil_rsp.rresp = rresp_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb0_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= fcled_pkg::RESP_OKAY;
    end else begin
      if (axil_req.awvalid && axil_rsp.awready) begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= axil_req.awaddr;
      end
      if (axil_req.wvalid && axil_rsp.wready) begin
        w_got_reg <= 1'b1;
        wdata_reg <= axil_req.wdata;
        wstrb0_reg <= axil_req.wstrb[0];
      end
      if (do_write) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        unique case (awaddr_reg)
          fcled_pkg::OFF_CTRL, fcled_pkg::OFF_STATUS,
          fcled_pkg::OFF_IRQ_STAT, fcled_pkg::OFF_IRQ_MASK: bresp_reg <= fcled_pkg::RESP_OKAY;
          default: bresp_reg <= fcled_pkg::RESP_SLVERR;
        endcase
      end else if (bvalid_reg && axil_req.bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_en_reg <= fcled_pkg::CTRL_EN_RST;
      irq_mask_reg <= fcled_pkg::IRQ_MASK_RST;
    end else if (wr_ok) begin
      if (awaddr_reg == fcled_pkg::OFF_CTRL) begin
        ctrl_en_reg <= wdata_reg[fcled_pkg::CTRL_EN_BIT];
      end
      if (awaddr_reg == fcled_pkg::OFF_IRQ_MASK) begin
        irq_mask_reg <= wdata_reg[2:0];
      end
    end
  end

  // Set beats clear so an event in the clearing cycle is kept
  assign irq_set = {ev_seq, ev_dem, ev_err};
  assign irq_clr = (wr_ok && awaddr_reg == fcled_pkg::OFF_IRQ_STAT) ? wdata_reg[2:0] : 3'h0;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_reg <= 3'h0;
      irq <= 1'b0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
      irq <= |(((irq_stat_reg & ~irq_clr) | irq_set) & irq_mask_reg);
    end
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[fcled_pkg::ST_STATE_LSB +: 3] = state_reg;
    status_word[fcled_pkg::ST_STAGE_LSB +: 2] = stage_reg;
    status_word[fcled_pkg::ST_CODE_LSB +: 4] = code_reg;
    status_word[fcled_pkg::ST_ERRM_BIT] = speed_mismatch;
    status_word[fcled_pkg::ST_ERRC_BIT] = crc_fail;
    status_word[fcled_pkg::ST_RPM_LSB +: 10] = motor_drive_rpm;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= fcled_pkg::RESP_OKAY;
    end else if (axil_req.arvalid && axil_rsp.arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= fcled_pkg::RESP_OKAY;
      unique case (axil_req.araddr)
        fcled_pkg::OFF_CTRL: rdata_reg <= {31'h0000_0000, ctrl_en_reg};
        fcled_pkg::OFF_STATUS: rdata_reg <= status_word;
        fcled_pkg::OFF_IRQ_STAT: rdata_reg <= {29'h0000_0000, irq_stat_reg};
        fcled_pkg::OFF_IRQ_MASK: rdata_reg <= {29'h0000_0000, irq_mask_reg};
        default: begin
          rdata_reg <= 32'h0000_0000;
          rresp_reg <= fcled_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && axil_req.rready) begin
      rvalid_reg <= 1'b0;
    end
  end

endmodule : fcled_seq

// ### fcled_seq_monitor.sv
// Port-level checks of the fan status LED sequencer
`timescale 1ns/10ps
module fcled_seq_monitor #(
  parameter int unsigned FAST_HALF_CYC = 3,
  parameter int unsigned SLOW_HALF_CYC = 5
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic first_stage_demand,
  input wire logic second_stage_demand,
  input wire logic [3:0] profile_pins,
  input wire logic speed_mismatch,
  input wire logic crc_fail,
  input wire logic status_led,
  input wire logic [9:0] motor_drive_rpm
);
  // ========
  // Helper logic
  logic led_q;
  logic [31:0] run_cnt;
  logic [31:0] quiet_cnt;
  logic [31:0] mis_cnt;
  wire lo_d = first_stage_demand && !second_stage_demand;
  wire hi_d = first_stage_demand && second_stage_demand;
  wire red_d = !first_stage_demand && second_stage_demand;
  wire led_chg = status_led != led_q;

  // Length of the current LED level
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      led_q <= 1'b0;
      run_cnt <= '0;
    end else begin
      led_q <= status_led;
      run_cnt <= led_chg ? '0 : run_cnt + 1;
    end
  end

  // Fault ages, so that aborted flashes are not judged as normal ones
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      quiet_cnt <= '0;
      mis_cnt <= '0;
    end else begin
      quiet_cnt <= (speed_mismatch || crc_fail) ? '0 : quiet_cnt + 1;
      mis_cnt <= (speed_mismatch && !crc_fail) ? mis_cnt + 1 : '0;
    end
  end

  // ========
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence crc_gone_s;
    $fell(crc_fail) && !speed_mismatch;
  endsequence
  crc_on_a:
  assert property (crc_fail [*4] |-> status_led) else $error("LED not on during checksum fault");
  fast_flash_a:
  assert property (mis_cnt > 2 * FAST_HALF_CYC + 4 && led_chg |-> run_cnt == FAST_HALF_CYC - 1)
    else $error("fast flash half length wrong");
  slow_on_a:
  assert property (quiet_cnt > 2 * SLOW_HALF_CYC + 4 && led_q && !status_led |-> run_cnt == SLOW_HALF_CYC - 1)
    else $error("slow flash on time wrong");
  err_exit_a:
  assert property (crc_gone_s |-> ##[1:2] !status_led) else $error("LED not off after fault cleared");
  rpm_low_a:
  assert property (lo_d && profile_pins == 4'hC |=> motor_drive_rpm == 10'h1DB) else $error("low target wrong");
  rpm_high_a:
  assert property (hi_d && profile_pins == 4'hB |=> motor_drive_rpm == 10'h258) else $error("high target wrong");
  rpm_red_a:
  assert property (red_d && profile_pins == 4'h9 |=> motor_drive_rpm == 10'h0E1) else $error("reduced target wrong");
  rpm_idle_a:
  assert property (!first_stage_demand && !second_stage_demand |=> motor_drive_rpm == 10'h000)
    else $error("target not zero without demand");
endmodule : fcled_seq_monitor

bind fcled_seq fcled_seq_monitor #(.FAST_HALF_CYC(FAST_HALF_CYC), .SLOW_HALF_CYC(SLOW_HALF_CYC)) mon_u (
  .clk_sys(clk_sys), .rst_n(rst_n), .first_stage_demand(first_stage_demand),
  .second_stage_demand(second_stage_demand), .profile_pins(profile_pins), .speed_mismatch(speed_mismatch),
  .crc_fail(crc_fail), .status_led(status_led), .motor_drive_rpm(motor_drive_rpm));

// ### fcled_partner.sv
// Thermostat demand and fan motor feedback model
`timescale 1ns/10ps
module fcled_partner (
  input wire logic clk_sys,
  input wire logic [1:0] stage_cmd,
  input wire logic mis_cmd,
  input wire logic crc_cmd,
  input wire logic [9:0] motor_drive_rpm,
  output logic first_stage_demand,
  output logic second_stage_demand,
  output logic speed_mismatch,
  output logic crc_fail
);
  logic [9:0] motor_rpm;
  // Outputs settle at the first clock edge, well inside the reset hold
  // A stalled motor stops, so its feedback differs from a nonzero target
  always @(posedge clk_sys) begin
    motor_rpm <= mis_cmd ? 10'h000 : motor_drive_rpm;
    speed_mismatch <= mis_cmd && (motor_rpm !== motor_drive_rpm);
    first_stage_demand <= stage_cmd == 2'h1 || stage_cmd == 2'h2;
    second_stage_demand <= stage_cmd[1];
    crc_fail <= crc_cmd;
  end
endmodule : fcled_partner

// ### test_fcled_seq.sv
// Self-checking bench for the fan status LED sequencer
`timescale 1ns/10ps
module test_fcled_seq;
  localparam int FH = 3;
  localparam int SH = 5;
  localparam int SP = 20;
  localparam int LP = 50;
  logic clk_sys;
  logic rst_n;
  fcled_pkg::fcled_axil_req_t req;
  fcled_pkg::fcled_axil_rsp_t rsp;
  logic [3:0] profile_pins;
  logic [1:0] stage_cmd;
  logic mis_cmd;
  logic crc_cmd;
  logic first_stage_demand;
  logic second_stage_demand;
  logic speed_mismatch;
  logic crc_fail;
  logic status_led;
  logic [9:0] motor_drive_rpm;
  logic irq;
  logic led_q;
  logic [31:0] q;
  logic [1:0] r;
  int n_fail;
  int check_count;
  int run_len;
  int runs[$];
  int exp_runs[$];
  logic [3:0] prof_t [3] = '{4'hC, 4'hB, 4'h9};
  logic [3:0] code_t [3][3] = '{'{4'h6, 4'h8, 4'h3}, '{4'h7, 4'h8, 4'h3}, '{4'h8, 4'h9, 4'h3}};
  logic [9:0] rpm_t [3][3] = '{'{10'h1DB, 10'h226, 10'h0C8}, '{10'h20D, 10'h258, 10'h0E1},
                               '{10'h258, 10'h2A3, 10'h0E1}};

  fcled_seq #(.FAST_HALF_CYC(FH), .SLOW_HALF_CYC(SH), .SHORT_PAUSE_CYC(SP), .LONG_PAUSE_CYC(LP)) dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .axil_req(req), .axil_rsp(rsp), .first_stage_demand(first_stage_demand),
    .second_stage_demand(second_stage_demand), .profile_pins(profile_pins), .speed_mismatch(speed_mismatch),
    .crc_fail(crc_fail), .status_led(status_led), .motor_drive_rpm(motor_drive_rpm), .irq(irq));
  fcled_partner partner_u (.clk_sys(clk_sys), .stage_cmd(stage_cmd), .mis_cmd(mis_cmd), .crc_cmd(crc_cmd),
    .motor_drive_rpm(motor_drive_rpm), .first_stage_demand(first_stage_demand),
    .second_stage_demand(second_stage_demand), .speed_mismatch(speed_mismatch), .crc_fail(crc_fail));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // LED run lengths, sampled on the falling edge away from the launching edge
  always @(negedge clk_sys) begin
    if (status_led !== led_q) begin
      runs.push_back(run_len);
      run_len = 1;
    end else begin
      run_len++;
    end
    led_q = status_led;
  end

  // ========
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    check_count++;
    if (got !== want) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, want);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
                     output logic [1:0] resp);
    int t;
    logic done;
    logic aw_tk;
    logic w_tk;
    logic ar_tk;
    t = 0;
    done = 1'b0;
    @(posedge clk_sys);
    if (wr) begin
      req.awaddr <= a;
      req.wdata <= d;
      req.wstrb <= 4'hF;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
    end else begin
      req.araddr <= a;
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
    end
    while (done !== 1'b1 && t < 100) begin
      @(negedge clk_sys);
      t++;
      aw_tk = req.awvalid && rsp.awready;
      w_tk = req.wvalid && rsp.wready;
      ar_tk = req.arvalid && rsp.arready;
      done = wr ? rsp.bvalid : rsp.rvalid;
      rd = rsp.rdata;
      resp = wr ? rsp.bresp : rsp.rresp;
      @(posedge clk_sys);
      if (aw_tk) req.awvalid <= 1'b0;
      if (w_tk) req.wvalid <= 1'b0;
      if (ar_tk) req.arvalid <= 1'b0;
    end
    req.bready <= 1'b0;
    req.rready <= 1'b0;
    if (done !== 1'b1) chk(32'h0, 32'h1);
  endtask : bus

  task automatic wait_runs(input int n);
    int t;
    t = 0;
    while (runs.size() < n && t < 3000) begin
      @(negedge clk_sys);
      t++;
    end
    chk(32'(runs.size()), 32'(n));
  endtask : wait_runs

  // Expected on/off lengths of one full pass, from the idle start to the restart
  task automatic seq_check(input int st, input int code);
    exp_runs.delete();
    for (int i = 1; i <= st; i++) begin
      exp_runs.push_back(SH);
      exp_runs.push_back(i == st ? SH + LP : SH);
    end
    for (int j = 1; j <= code; j++) begin
      exp_runs.push_back(SH);
      exp_runs.push_back(j == code ? SH + SP + 1 : SH);
    end
    wait_runs(exp_runs.size() + 1);
    foreach (exp_runs[i]) chk(32'(runs[i + 1]), 32'(exp_runs[i]));
  endtask : seq_check

  // Longer LED-off time than any gap inside a pass means the pass is over
  task automatic idle_wait();
    int t;
    t = 0;
    while (!(status_led === 1'b0 && run_len > SH + LP + SP) && t < 3000) begin
      @(negedge clk_sys);
      t++;
    end
    chk(32'(status_led), 32'h0);
  endtask : idle_wait

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  // ========
  // Tests
  initial begin
    rst_n = 1'b0;
    req = '0;
    profile_pins = 4'h0;
    stage_cmd = 2'h0;
    mis_cmd = 1'b0;
    crc_cmd = 1'b0;
    n_fail = 0;
    check_count = 0;
    run_len = 0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    bus(1'b0, fcled_pkg::OFF_CTRL, 32'h0, q, r);
    chk(q, 32'h1);
    bus(1'b0, fcled_pkg::OFF_IRQ_MASK, 32'h0, q, r);
    chk(q, 32'h0);
    bus(1'b1, 8'h40, 32'h1, q, r);
    chk(32'(r), 32'(fcled_pkg::RESP_SLVERR));
    bus(1'b0, 8'h40, 32'h0, q, r);
    chk(32'(r), 32'(fcled_pkg::RESP_SLVERR));
    for (int p = 0; p < 3; p++) begin
      for (int s = 1; s < 4; s++) begin
        @(posedge clk_sys);
        profile_pins <= prof_t[p];
        stage_cmd <= 2'(s);
        runs.delete();
        seq_check(s, 32'(code_t[p][s - 1]));
        chk(32'(motor_drive_rpm), 32'(rpm_t[p][s - 1]));
        chk(32'(irq), 32'h0);
        @(posedge clk_sys);
        stage_cmd <= 2'h0;
        idle_wait();
        chk(32'(motor_drive_rpm), 32'h0);
      end
    end
    bus(1'b1, fcled_pkg::OFF_IRQ_MASK, 32'h1, q, r);
    @(posedge clk_sys);
    stage_cmd <= 2'h1;
    runs.delete();
    wait_runs(2);
    @(posedge clk_sys);
    mis_cmd <= 1'b1;
    runs.delete();
    wait_runs(6);
    for (int i = 2; i < 6; i++) chk(32'(runs[i]), 32'(FH));
    chk(32'(irq), 32'h1);
    bus(1'b0, fcled_pkg::OFF_IRQ_STAT, 32'h0, q, r);
    chk(32'(q[0]), 32'h1);
    crc_cmd <= 1'b1;
    repeat (10) @(negedge clk_sys);
    runs.delete();
    repeat (40) @(negedge clk_sys);
    chk(32'(runs.size()), 32'h0);
    chk(32'(status_led), 32'h1);
    @(posedge clk_sys);
    mis_cmd <= 1'b0;
    crc_cmd <= 1'b0;
    stage_cmd <= 2'h0;
    idle_wait();
    bus(1'b1, fcled_pkg::OFF_IRQ_STAT, 32'h7, q, r);
    repeat (2) @(negedge clk_sys);
    chk(32'(irq), 32'h0);
    @(posedge clk_sys);
    crc_cmd <= 1'b1;
    stage_cmd <= 2'h2;
    rst_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    runs.delete();
    repeat (60) @(negedge clk_sys);
    chk(32'(runs.size()), 32'h1);
    chk(32'(status_led), 32'h1);
    bus(1'b0, fcled_pkg::OFF_STATUS, 32'h0, q, r);
    chk(32'(q[fcled_pkg::ST_STATE_LSB +: 3]), 32'(fcled_pkg::FCLED_ERR));
    chk(32'(q[fcled_pkg::ST_ERRC_BIT]), 32'h1);
    @(posedge clk_sys);
    crc_cmd <= 1'b0;
    stage_cmd <= 2'h0;
    idle_wait();
    test_done();
  end

  initial begin
    repeat (30000) @(posedge clk_sys);
    n_fail++;
    test_done();
  end
endmodule : test_fcled_seq
